/* src/apx_pkg.sv */
// Constants for the configurable port channel path: register map,
// field positions, reset values and structural limits.
// Assumes a single 50 MHz system clock and a 32-bit Avalon-MM slave bus.
package apx_pkg;

    // Datapath
    localparam int DATA_W = 32;
    localparam int BURST_W = 2;
    localparam int PAYLOAD_W = DATA_W + BURST_W;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_CNT_W = 4;

    // Optional stage slots before and after the buffer
    localparam int PRE_SLOTS = 5;
    localparam int POST_SLOTS = 12;
    localparam int DIE_SLOTS = 3;
    localparam int PAY_SLOTS = 3;
    localparam int SYNC_SLOTS = 8;
    localparam logic [3:0] SYNC_MIN = 4'h2;
    localparam logic [3:0] SYNC_MAX = 4'h8;

    // Register byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_PIPE = 4'h4;
    localparam logic [3:0] OFS_CLK = 4'h8;
    localparam logic [3:0] OFS_STAT = 4'hC;

    // Control register fields
    localparam int CTRL_LITE = 0;
    localparam int CTRL_OUTER = 1;
    localparam int CTRL_INNER = 2;
    localparam int CTRL_HSHK = 3;
    localparam int CTRL_DATA_CH = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_000E;

    // Pipeline register fields
    localparam int PIPE_DIE_LSB = 0;
    localparam int PIPE_PAY_LSB = 2;
    localparam int PIPE_SYNC_LSB = 4;
    localparam int PIPE_CMD_DEPTH_LSB = 8;
    localparam int PIPE_DATA_DEPTH_LSB = 12;
    localparam int PIPE_SW_LSB = 16;
    localparam logic [31:0] PIPE_RESET = 32'h0000_6630;

    // Clock relation register fields
    localparam int CLK_SAME = 0;
    localparam int CLK_UP_LSB = 1;
    localparam int CLK_DN_LSB = 6;
    localparam logic [31:0] CLK_RESET = 32'h0000_0043;
    localparam logic [4:0] RATIO_MAX = 5'h10;

    // Status register fields
    localparam int STAT_LITE = 0;
    localparam int STAT_ASYNC = 1;
    localparam int STAT_SW_LSB = 2;
    localparam int STAT_BRAM = 5;
    localparam int STAT_CNT_LSB = 6;
    localparam int STAT_DEPTH_LSB = 10;

    // Depth codes: 0 is no buffer, k names 2**(k-1) entries; the buffer stores at most 8
    localparam logic [3:0] CMD_DEPTH_MAX = 4'h6;
    localparam logic [3:0] DATA_DEPTH_MAX = 4'hD;
    localparam logic [3:0] DEFAULT_DEPTH = 4'h6;
    localparam logic [3:0] BRAM_DEPTH = 4'hA;
    localparam logic [3:0] FULL_DEPTH = 4'h4;

    // Switchboard width codes: 0 automatic, 1..6 for 32..1024 bits
    localparam logic [2:0] SW_AUTO = 3'h0;
    localparam logic [2:0] SW_32 = 3'h1;
    localparam logic [2:0] SW_1024 = 3'h6;

    // Burst and response encodings
    localparam logic [1:0] BURST_WRAP = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : apx_pkg

/* src/apx_port_path.sv */
// Functional notes
// - Command and response buffer depth 0,1,2,4,8,16,32; default 32; the buffer stores at most 8.
// - Data buffers take depth 0 or powers of two up to 4096; default 32; the buffer stores at most 8.
// - Data buffers of 512 entries or more count as block memory.
// - Lite-only downstream: low-area mode; buffer, width, slice ignored.
// - Low-area mode refuses incoming WRAP bursts with a DECERR response.
// - Low-area mode fixes the switchboard width at 32 bits.
// - Else switchboard width is 32 to 1024 bits, automatic by default.
// - Low-area mode removes every optional register slice except the synchronizer stages.
// - Optional outer port register slice, present by default.
// - Optional inner entry register slice, present by default.
// - Zero to three die-crossing stages per channel buffer, default zero.
// - Zero to three payload stages after the buffer, default zero.
// - Optional handshake stage after the buffer, present by default.
// - Async crossing: two to eight synchronizer stages, default three.
// - Same source and ratio 1:16 to 16:1 is synchronous, else async.
//
// One channel path: entry skid, optional slices, buffer, optional stages,
// exit register. Assumes configuration changes only while the path is empty.
`timescale 1ns/1ps

module apx_slice #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Stage enable, bypass when low
    input wire logic en,
    // Upstream
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Downstream
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic valid_reg;
    logic [WIDTH-1:0] data_reg;

    assign in_ready = en ? (!valid_reg || out_ready) : out_ready;
    assign out_valid = en ? valid_reg : in_valid;
    assign out_data = en ? data_reg : in_data;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            valid_reg <= 1'b0;
        end else if (en && (!valid_reg || out_ready)) begin
            valid_reg <= in_valid;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (en && in_valid && (!valid_reg || out_ready)) begin
            data_reg <= in_data;
        end
    end
endmodule : apx_slice

module apx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Occupancy cap
    input wire logic [$clog2(DEPTH+1)-1:0] limit,
    output logic [$clog2(DEPTH+1)-1:0] count,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [$clog2(DEPTH+1)-1:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = count_reg < limit;
    assign out_valid = count_reg != '0;
    assign out_data = mem[rd_ptr_reg];
    assign count = count_reg;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0
                    : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0
                    : rd_ptr_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
        end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    a_fifo_cap: assert property (
        @(posedge sys_clk) disable iff (rst)
        push && !pop |=> count_reg <= limit && count_reg != '0)
        else $error("fifo accepted beyond its depth cap");
endmodule : apx_fifo

module apx_port_path
    import apx_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Avalon-MM register slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Inbound channel from the master side
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [DATA_W-1:0] s_data,
    input wire logic [BURST_W-1:0] s_burst,
    // Outbound channel toward the switchboard
    output logic m_valid,
    input wire logic m_ready,
    output logic [DATA_W-1:0] m_data,
    output logic [BURST_W-1:0] m_burst,
    // Error response for refused bursts
    output logic resp_valid,
    input wire logic resp_ready,
    output logic [1:0] resp_code
);
    logic [31:0] ctrl_reg;
    logic [31:0] pipe_reg;
    logic [31:0] clk_reg;
    logic [31:0] rdata_next;
    logic [31:0] stat_word;
    logic wait_reg;
    logic [31:0] readdata_reg;
    logic lite;
    logic data_ch;
    logic async_mode;
    logic ratio_ok;
    logic [4:0] up_ratio;
    logic [4:0] dn_ratio;
    logic [3:0] sync_raw;
    logic [3:0] sync_n;
    logic [3:0] depth_raw;
    logic [3:0] depth_max;
    logic [3:0] depth_code;
    logic [3:0] fifo_limit;
    logic [3:0] fifo_count;
    logic fifo_bypass;
    logic bram_class;
    logic [2:0] sw_raw;
    logic [2:0] sw_eff;
    logic [PRE_SLOTS-1:0] pre_en;
    logic [POST_SLOTS-1:0] post_en;

    function automatic logic [31:0] merge_be(input logic [31:0] old_v,
            input logic [31:0] new_v, input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction : merge_be

    // Bus answers one cycle after the request is seen
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= !((avs_read || avs_write) && wait_reg);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            readdata_reg <= 32'h0000_0000;
        end else if (avs_read && wait_reg) begin
            readdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= CTRL_RESET;
            pipe_reg <= PIPE_RESET;
            clk_reg <= CLK_RESET;
        end else if (avs_write && !wait_reg) begin
            case (avs_address)
                OFS_CTRL: ctrl_reg <= merge_be(ctrl_reg, avs_writedata,
                    avs_byteenable);
                OFS_PIPE: pipe_reg <= merge_be(pipe_reg, avs_writedata,
                    avs_byteenable);
                OFS_CLK: clk_reg <= merge_be(clk_reg, avs_writedata,
                    avs_byteenable);
                default: ;
            endcase
        end
    end

    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[STAT_LITE] = lite;
        stat_word[STAT_ASYNC] = async_mode;
        stat_word[STAT_SW_LSB +: 3] = sw_eff;
        stat_word[STAT_BRAM] = bram_class;
        stat_word[STAT_CNT_LSB +: 4] = fifo_count;
        stat_word[STAT_DEPTH_LSB +: 4] = depth_code;
        case (avs_address)
            OFS_CTRL: rdata_next = ctrl_reg;
            OFS_PIPE: rdata_next = pipe_reg;
            OFS_CLK: rdata_next = clk_reg;
            OFS_STAT: rdata_next = stat_word;
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata = readdata_reg;

    assign lite = ctrl_reg[CTRL_LITE];
    assign data_ch = ctrl_reg[CTRL_DATA_CH];

    assign up_ratio = clk_reg[CLK_UP_LSB +: 5];
    assign dn_ratio = clk_reg[CLK_DN_LSB +: 5];
    assign ratio_ok = (up_ratio == 5'h01 && dn_ratio != 5'h00
            && dn_ratio <= RATIO_MAX)
        || (dn_ratio == 5'h01 && up_ratio != 5'h00 && up_ratio <= RATIO_MAX);
    assign async_mode = !(clk_reg[CLK_SAME] && ratio_ok);

    assign sync_raw = pipe_reg[PIPE_SYNC_LSB +: 4];
    assign sync_n = (sync_raw < SYNC_MIN) ? SYNC_MIN
        : ((sync_raw > SYNC_MAX) ? SYNC_MAX : sync_raw);

    assign depth_raw = data_ch ? pipe_reg[PIPE_DATA_DEPTH_LSB +: 4]
        : pipe_reg[PIPE_CMD_DEPTH_LSB +: 4];
    assign depth_max = data_ch ? DATA_DEPTH_MAX : CMD_DEPTH_MAX;
    assign depth_code = lite ? DEFAULT_DEPTH
        : ((depth_raw > depth_max) ? depth_max : depth_raw);
    assign fifo_bypass = depth_code == 4'h0;
    assign fifo_limit = (depth_code >= FULL_DEPTH) ? 4'(FIFO_DEPTH)
        : ((depth_code == 4'h0) ? 4'h0 : 4'(1 << (depth_code - 4'h1)));

    assign bram_class = data_ch && depth_code >= BRAM_DEPTH;

    assign sw_raw = pipe_reg[PIPE_SW_LSB +: 3];
    assign sw_eff = (lite || sw_raw == SW_AUTO || sw_raw > SW_1024)
        ? SW_32 : sw_raw;

    always_comb begin
        pre_en[0] = !lite && ctrl_reg[CTRL_OUTER];
        pre_en[1] = !lite && ctrl_reg[CTRL_INNER];
        for (int i = 0; i < DIE_SLOTS; i++) begin
            pre_en[2+i] = !lite && (2'(i) < pipe_reg[PIPE_DIE_LSB +: 2]);
        end
        for (int i = 0; i < PAY_SLOTS; i++) begin
            post_en[i] = !lite && (2'(i) < pipe_reg[PIPE_PAY_LSB +: 2]);
        end
        post_en[PAY_SLOTS] = !lite && ctrl_reg[CTRL_HSHK];
        for (int i = 0; i < SYNC_SLOTS; i++) begin
            post_en[PAY_SLOTS+1+i] = async_mode && (4'(i) < sync_n);
        end
    end

    // Entry skid buffer keeps s_ready registered
    logic ent_valid_reg;
    logic [PAYLOAD_W-1:0] ent_data_reg;
    logic skid_valid_reg;
    logic [PAYLOAD_W-1:0] skid_data_reg;
    logic s_ready_reg;
    logic ent_take;
    logic is_wrap;
    logic wrap_take;
    logic resp_valid_reg;
    logic [1:0] resp_code_reg;

    // skid holds the beat in flight
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ent_valid_reg <= 1'b0;
            skid_valid_reg <= 1'b0;
            s_ready_reg <= 1'b1;
        end else if (ent_take || !ent_valid_reg) begin
            ent_valid_reg <= skid_valid_reg || (s_valid && s_ready_reg);
            skid_valid_reg <= 1'b0;
            s_ready_reg <= 1'b1;
        end else if (s_valid && s_ready_reg) begin
            skid_valid_reg <= 1'b1;
            s_ready_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (ent_take || !ent_valid_reg) begin
            ent_data_reg <= skid_valid_reg ? skid_data_reg
                : {s_burst, s_data};
        end else if (s_valid && s_ready_reg) begin
            skid_data_reg <= {s_burst, s_data};
        end
    end

    assign s_ready = s_ready_reg;

    assign is_wrap = lite && ent_data_reg[DATA_W +: BURST_W] == BURST_WRAP;
    assign wrap_take = ent_valid_reg && is_wrap
        && (!resp_valid_reg || resp_ready);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            resp_valid_reg <= 1'b0;
            resp_code_reg <= 2'h0;
        end else if (wrap_take) begin
            resp_valid_reg <= 1'b1;
            resp_code_reg <= RESP_DECERR;
        end else if (resp_ready) begin
            resp_valid_reg <= 1'b0;
        end
    end

    assign resp_valid = resp_valid_reg;
    assign resp_code = resp_code_reg;

    // Stage chains around the buffer
    logic pre_v [0:PRE_SLOTS];
    logic pre_r [0:PRE_SLOTS];
    logic [PAYLOAD_W-1:0] pre_d [0:PRE_SLOTS];
    logic post_v [0:POST_SLOTS];
    logic post_r [0:POST_SLOTS];
    logic [PAYLOAD_W-1:0] post_d [0:POST_SLOTS];
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [PAYLOAD_W-1:0] fifo_out_data;

    assign pre_v[0] = ent_valid_reg && !is_wrap;
    assign pre_d[0] = ent_data_reg;
    assign ent_take = is_wrap ? wrap_take : pre_r[0];

    genvar g;
    generate
        for (g = 0; g < PRE_SLOTS; g++) begin : g_pre
            apx_slice #(.WIDTH(PAYLOAD_W)) u_slice (
                .sys_clk(sys_clk),
                .rst(rst),
                .en(pre_en[g]),
                .in_valid(pre_v[g]),
                .in_ready(pre_r[g]),
                .in_data(pre_d[g]),
                .out_valid(pre_v[g+1]),
                .out_ready(pre_r[g+1]),
                .out_data(pre_d[g+1])
            );
        end
        for (g = 0; g < POST_SLOTS; g++) begin : g_post
            apx_slice #(.WIDTH(PAYLOAD_W)) u_slice (
                .sys_clk(sys_clk),
                .rst(rst),
                .en(post_en[g]),
                .in_valid(post_v[g]),
                .in_ready(post_r[g]),
                .in_data(post_d[g]),
                .out_valid(post_v[g+1]),
                .out_ready(post_r[g+1]),
                .out_data(post_d[g+1])
            );
        end
    endgenerate

    // Depth code zero means no buffer at all
    assign pre_r[PRE_SLOTS] = fifo_bypass ? post_r[0] : fifo_in_ready;
    assign post_v[0] = fifo_bypass ? pre_v[PRE_SLOTS] : fifo_out_valid;
    assign post_d[0] = fifo_bypass ? pre_d[PRE_SLOTS] : fifo_out_data;

    apx_fifo #(.WIDTH(PAYLOAD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .limit(fifo_limit),
        .count(fifo_count),
        .in_valid(pre_v[PRE_SLOTS] && !fifo_bypass),
        .in_ready(fifo_in_ready),
        .in_data(pre_d[PRE_SLOTS]),
        .out_valid(fifo_out_valid),
        .out_ready(post_r[0] && !fifo_bypass),
        .out_data(fifo_out_data)
    );

    // Exit register
    logic m_valid_reg;
    logic [PAYLOAD_W-1:0] m_data_reg;

    assign post_r[POST_SLOTS] = !m_valid_reg || m_ready;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            m_valid_reg <= 1'b0;
        end else if (!m_valid_reg || m_ready) begin
            m_valid_reg <= post_v[POST_SLOTS];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (post_v[POST_SLOTS] && (!m_valid_reg || m_ready)) begin
            m_data_reg <= post_d[POST_SLOTS];
        end
    end

    assign m_valid = m_valid_reg;
    assign m_data = m_data_reg[DATA_W-1:0];
    assign m_burst = m_data_reg[DATA_W +: BURST_W];

    // Checks
    a_bus_answer: assert property (
        @(posedge sys_clk) disable iff (rst)
        (avs_read || avs_write) && wait_reg |=> !wait_reg ##1 wait_reg)
        else $error("bus answer not exactly one cycle after request");

    a_wrap_decerr: assert property (
        @(posedge sys_clk) disable iff (rst)
        wrap_take |=> resp_valid_reg && resp_code_reg == RESP_DECERR)
        else $error("wrap burst not answered with decerr");

    a_wrap_blocked: assert property (
        @(posedge sys_clk) disable iff (rst)
        lite && pre_v[0] |-> pre_d[0][DATA_W +: BURST_W] != BURST_WRAP)
        else $error("wrap burst forwarded in low-area mode");

    a_lite_slices: assert property (
        @(posedge sys_clk) disable iff (rst)
        lite |-> pre_en == '0 && post_en[PAY_SLOTS:0] == '0)
        else $error("optional slice active in low-area mode");

    a_lite_width: assert property (
        @(posedge sys_clk) disable iff (rst)
        lite |-> stat_word[STAT_SW_LSB +: 3] == SW_32)
        else $error("switchboard width not 32 in low-area mode");

    a_lite_depth: assert property (
        @(posedge sys_clk) disable iff (rst)
        lite |-> fifo_limit == 4'(FIFO_DEPTH) && !bram_class)
        else $error("buffer setting honoured in low-area mode");

    a_sync_count: assert property (
        @(posedge sys_clk) disable iff (rst)
        async_mode |-> $countones(post_en[POST_SLOTS-1:PAY_SLOTS+1]) >= 2
            && $countones(post_en[POST_SLOTS-1:PAY_SLOTS+1]) <= 8)
        else $error("synchronizer depth outside two to eight");

    a_sync_mode: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_reg[CLK_SAME] && up_ratio == 5'h01 && dn_ratio == 5'h10
        |-> !async_mode && post_en[POST_SLOTS-1:PAY_SLOTS+1] == '0)
        else $error("synchronous relation handled as asynchronous");

    a_exit_hold: assert property (
        @(posedge sys_clk) disable iff (rst)
        m_valid_reg && !m_ready |=> m_valid_reg && $stable(m_data_reg))
        else $error("exit beat dropped or changed under back-pressure");

    a_skid_full: assert property (
        @(posedge sys_clk) disable iff (rst)
        !s_ready_reg |-> skid_valid_reg && ent_valid_reg)
        else $error("entry stalled with room to spare");
endmodule : apx_port_path

/* tb/apx_sink_model.sv */
// Far-side sink: takes outbound beats and refusal responses.
// Assumes the bench sets the stall chance; 100 holds both readies low.
`timescale 1ns/1ps
module apx_sink_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Stall chance in percent
    input wire logic [7:0] stall_pct,
    // Readies toward the path
    output logic m_ready,
    output logic resp_ready
);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            m_ready <= 1'b0;
            resp_ready <= 1'b0;
        end else begin
            m_ready <= ($urandom % 100) >= stall_pct;
            resp_ready <= ($urandom % 100) >= stall_pct;
        end
    end
endmodule : apx_sink_model

/* tb/axi_port_buffer_pipeline_tb.sv */
// Bench for the port path: register bus, stream, queue model.
// Assumes the sink model drives the ready inputs.
`timescale 1ns/1ps
module axi_port_buffer_pipeline_tb;
    import apx_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rd, st;
    logic avs_waitrequest, s_ready, m_valid, m_ready, resp_valid, resp_ready;
    logic s_valid = 1'b0;
    logic [DATA_W-1:0] s_data = '0;
    logic [BURST_W-1:0] s_burst = '0;
    logic [DATA_W-1:0] m_data;
    logic [BURST_W-1:0] m_burst;
    logic [1:0] resp_code;
    logic [7:0] stall_pct = 8'h0;
    logic [PAYLOAD_W-1:0] exp_q[$];
    logic lite = 1'b0;
    int n_errors = 0;
    int check_count = 0;
    int n_resp = 0;
    int exp_resp = 0;
    logic [31:0] clk_tab [4] = '{32'h42, 32'h61, 32'h63, 32'h43};
    // Async expected: other source, sync at 16:1, async at 17:1, sync at 1:1
    logic [3:0] clk_async = 4'h5;
    apx_port_path apx_port_path_inst (.sys_clk(sys_clk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .s_valid(s_valid),
        .s_ready(s_ready), .s_data(s_data), .s_burst(s_burst),
        .m_valid(m_valid), .m_ready(m_ready), .m_data(m_data),
        .m_burst(m_burst), .resp_valid(resp_valid),
        .resp_ready(resp_ready), .resp_code(resp_code));
    apx_sink_model apx_sink_model_inst (.sys_clk(sys_clk), .rst(rst),
        .stall_pct(stall_pct), .m_ready(m_ready), .resp_ready(resp_ready));
    initial forever #10 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    task automatic ran_out;
        n_errors++;
        $display("FAIL %0t wait ran out", $time);
        finish_test();
    endtask : ran_out
    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a,
            input logic [31:0] d);
        int w;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        for (w = 0; w < 50; w++) begin
            @(posedge sys_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (w == 50) ran_out();
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    // Back-to-back beats; a fill run reads occupancy once it stalls
    task automatic send(input int n, input logic [1:0] b, input bit fill);
        int i, w;
        logic [31:0] d;
        @(posedge sys_clk);
        for (i = 0; i < n; i++) begin
            d = $urandom;
            s_valid <= 1'b1;
            s_data <= d;
            s_burst <= b;
            w = 0;
            do begin
                @(posedge sys_clk);
                w++;
                if (w == 40 && fill) begin
                    bus(1'b0, OFS_STAT, 32'h0);
                    chk(32'(rd[9:6]), 32'(FIFO_DEPTH));
                    stall_pct <= 8'h0;
                    fill = 1'b0;
                    w = 0;
                end
            end while (s_ready !== 1'b1 && w < 40);
            if (w == 40) ran_out();
            if (lite && b == BURST_WRAP) exp_resp++;
            else exp_q.push_back({b, d});
        end
        s_valid <= 1'b0;
    endtask : send
    task automatic drain;
        int w;
        for (w = 0; w < 400 && (exp_q.size() != 0 || n_resp != exp_resp); w++)
            @(posedge sys_clk);
        if (w == 400) ran_out();
        chk(32'(n_resp), 32'(exp_resp));
    endtask : drain
    always @(posedge sys_clk) begin
        if (!rst && m_valid === 1'b1 && m_ready === 1'b1) begin
            check_count++;
            if (exp_q.size() == 0
                || {m_burst, m_data} !== exp_q.pop_front()) begin
                n_errors++;
                $display("FAIL %0t outbound beat differs", $time);
            end
        end
        if (!rst && resp_valid === 1'b1 && resp_ready === 1'b1) begin
            n_resp++;
            chk(32'(resp_code), 32'(RESP_DECERR));
        end
    end
    initial begin
        void'($urandom(32'h2f39e219));
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        bus(1'b0, OFS_CTRL, 32'h0);
        chk(rd, CTRL_RESET);
        bus(1'b0, OFS_PIPE, 32'h0);
        chk(rd, PIPE_RESET);
        bus(1'b0, OFS_CLK, 32'h0);
        chk(rd, CLK_RESET);
        bus(1'b0, OFS_STAT, 32'h0);
        st = rd;
        chk(rd, 32'h0000_1804);
        bus(1'b1, OFS_STAT, 32'hFFFF_FFFF);
        bus(1'b0, OFS_STAT, 32'h0);
        chk(rd, st);
        stall_pct <= 8'h1E;
        send(20, 2'h0, 1'b0);
        drain();
        stall_pct <= 8'h64;
        send(16, 2'h1, 1'b1);
        drain();
        bus(1'b1, OFS_CTRL, 32'h0000_0010);
        bus(1'b1, OFS_PIPE, 32'h0006_A63F);
        bus(1'b0, OFS_STAT, 32'h0);
        chk(rd, 32'h0000_2838);
        stall_pct <= 8'h1E;
        send(12, 2'h0, 1'b0);
        drain();
        bus(1'b1, OFS_PIPE, 32'h0001_983F);
        bus(1'b0, OFS_STAT, 32'h0);
        chk(rd, 32'h0000_2404);
        foreach (clk_tab[k]) begin
            bus(1'b1, OFS_CLK, clk_tab[k]);
            bus(1'b0, OFS_STAT, 32'h0);
            chk(32'(rd[STAT_ASYNC]), 32'(clk_async[k]));
            send(4, 2'h1, 1'b0);
            drain();
        end
        bus(1'b1, OFS_PIPE, 32'h0006_963F);
        bus(1'b1, OFS_CTRL, 32'h0000_000F);
        lite = 1'b1;
        bus(1'b0, OFS_STAT, 32'h0);
        chk(rd, 32'h0000_1805);
        for (int b = 0; b < 4; b++) send(5, 2'(b), 1'b0);
        drain();
        finish_test();
    end
endmodule : axi_port_buffer_pipeline_tb
